// ---- rtl/ehm_pkg.sv ----
package ehm_pkg;

    // ========================================
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ========================================
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DISP = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_WIN_ERR = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_TOT_ERR = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CLK_FREQ = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_SHORT = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_TEST_MODE = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_TEST_LEN = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_TEST_RES = 8'h24;

    // ========================================
    // command bits of OFS_CMD
    localparam int CMD_ERR_RESTART = 0;
    localparam int CMD_HIST_CLEAR = 1;
    localparam int CMD_SHORT_RESTART = 2;
    localparam int CMD_TEST_DISCARD = 3;

    // ========================================
    // status bits of OFS_STATUS, and the valid bit of OFS_TEST_RES
    localparam int ST_SYNC = 0;
    localparam int ST_BITS = 1;
    localparam int ST_PHASE = 2;
    localparam int ST_POWER = 3;
    localparam int ST_LOCK = 4;
    localparam int RES_VALID = 31;

    // ========================================
    // test length fields
    localparam int LEN_SS_LSB = 0;
    localparam int LEN_MM_LSB = 8;
    localparam int LEN_HH_LSB = 16;
    localparam logic [4:0] HOURS_MAX = 5'h18;
    localparam logic [5:0] MINUTES_MAX = 6'h3B;
    localparam logic [5:0] SECONDS_MAX = 6'h3B;

    // ========================================
    // timing
    localparam int CLK_MHZ = 250;
    localparam int TICK_MS = 20;
    localparam int WINDOW_MS = 1000;
    localparam int TICK_CYC = TICK_MS * CLK_MHZ * 1000;
    localparam int WIN_CYC = WINDOW_MS * CLK_MHZ * 1000;
    localparam logic [5:0] TICKS_PER_SEC = 6'h32;
    localparam logic [7:0] SHORT_EXPIRED = 8'hFF;

    // ========================================
    // types
    typedef enum logic [1:0] {
        DISP_TOTAL = 2'h0,
        DISP_WINDOW = 2'h1,
        DISP_TEST = 2'h2
    } ehm_disp_t;

    typedef enum logic [1:0] {
        TM_UNTIMED = 2'h0,
        TM_TIMED = 2'h1,
        TM_REPEAT = 2'h2
    } ehm_tmode_t;

    typedef struct packed {
        logic powerLoss;
        logic phaseErr;
        logic bitErr;
        logic syncLoss;
    } ehm_hist_t;

    typedef struct packed {
        logic [4:0] hours;
        logic [5:0] minutes;
        logic [5:0] seconds;
    } ehm_len_t;

endpackage

// ---- rtl/ehm_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module ehm_top
    import ehm_pkg::*;
#(
    parameter int TICK_CYCLES = ehm_pkg::TICK_CYC,
    parameter int WINDOW_CYCLES = ehm_pkg::WIN_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [ehm_pkg::ADDR_W-1:0] regAddr,
    input wire logic [ehm_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [ehm_pkg::DATA_W-1:0] regRdata,
    // detector events
    input wire logic syncLossEvt,
    input wire logic bitErrEvt,
    input wire logic phaseErrEvt,
    input wire logic powerLossEvt,
    input wire logic patternLock,
    input wire logic [ehm_pkg::DATA_W-1:0] rxClkFreq,
    input wire logic testRun,
    // indicators and settings
    output ehm_pkg::ehm_hist_t histLed,
    output logic lockLed,
    output ehm_pkg::ehm_disp_t dispMode,
    output ehm_pkg::ehm_tmode_t testMode,
    output ehm_pkg::ehm_len_t testLenApplied,
    output logic testLenActive,
    output logic prevResultValid
);

    // ========================================
    // checks
    if (TICK_CYCLES < 2 || WINDOW_CYCLES < 2) begin : g_chk
        $error("tick and window periods need at least two cycles");
    end
    // the read words pad and pack for a 32-bit path only
    if (DATA_W != 32) begin : g_chk_data
        $error("register data path must be 32 bits wide");
    end

    // ========================================
    // helpers
    function automatic logic [DATA_W-1:0] sat_inc(input logic [DATA_W-1:0] v);
        sat_inc = (v == {DATA_W{1'b1}}) ? v : v + 32'h1;
    endfunction

    function automatic logic [DATA_W-1:0] cyc_end(input int n);
        cyc_end = DATA_W'(n - 1);
    endfunction

    // ========================================
    // register decode
    wire logic hitCmd = regAddr == OFS_CMD;
    wire logic hitDisp = regAddr == OFS_DISP;
    wire logic hitStatus = regAddr == OFS_STATUS;
    wire logic hitWinErr = regAddr == OFS_WIN_ERR;
    wire logic hitTotErr = regAddr == OFS_TOT_ERR;
    wire logic hitClkFreq = regAddr == OFS_CLK_FREQ;
    wire logic hitShort = regAddr == OFS_SHORT;
    wire logic hitTestMode = regAddr == OFS_TEST_MODE;
    wire logic hitTestLen = regAddr == OFS_TEST_LEN;
    wire logic hitTestRes = regAddr == OFS_TEST_RES;

    wire logic cmdWr = regWr && hitCmd;
    wire logic errRestart = cmdWr && regWdata[CMD_ERR_RESTART];
    wire logic histClear = cmdWr && regWdata[CMD_HIST_CLEAR];
    wire logic shortRestart = cmdWr && regWdata[CMD_SHORT_RESTART];
    wire logic testDiscard = cmdWr && regWdata[CMD_TEST_DISCARD];
    wire logic statusRd = regRd && hitStatus;

    // ========================================
    // state
    ehm_hist_t hist_ff;
    logic lock_ff;
    ehm_disp_t disp_ff;
    ehm_tmode_t tmode_ff;
    ehm_len_t len_ff;
    ehm_len_t lenApplied_ff;
    logic lenActive_ff;
    logic [DATA_W-1:0] totErr_ff;
    logic [DATA_W-1:0] winCyc_ff;
    logic [DATA_W-1:0] winAcc_ff;
    logic [DATA_W-1:0] winErr_ff;
    logic [DATA_W-1:0] snapWin_ff;
    logic [DATA_W-1:0] snapTot_ff;
    logic [DATA_W-1:0] snapFreq_ff;
    logic [DATA_W-1:0] shortPre_ff;
    logic [5:0] shortTicks_ff;
    logic shortExpired_ff;
    logic [DATA_W-1:0] shortErr_ff;
    logic testRun_ff;
    logic [DATA_W-1:0] testAcc_ff;
    logic [DATA_W-1:0] prevRes_ff;
    logic prevValid_ff;
    logic [DATA_W-1:0] rdata_ff;

    // ========================================
    // history indicators
    wire ehm_hist_t histEvt = '{
        powerLoss: powerLossEvt,
        phaseErr: phaseErrEvt,
        bitErr: bitErrEvt,
        syncLoss: syncLossEvt
    };
    // a new event in the clear cycle survives the clear
    wire ehm_hist_t nxt_hist = histClear ? histEvt : (hist_ff | histEvt);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            hist_ff <= '0;
        end else begin
            hist_ff <= nxt_hist;
        end
    end

    // one cycle of lag keeps the lamp on a flip-flop like the others
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            lock_ff <= 1'b0;
        end else begin
            lock_ff <= patternLock;
        end
    end

    // ========================================
    // settings
    wire ehm_disp_t wrDisp = ehm_disp_t'(regWdata[1:0]);
    wire logic dispOk = wrDisp == DISP_TOTAL || wrDisp == DISP_WINDOW || wrDisp == DISP_TEST;
    wire ehm_tmode_t wrMode = ehm_tmode_t'(regWdata[1:0]);
    wire logic modeOk = wrMode == TM_UNTIMED || wrMode == TM_TIMED || wrMode == TM_REPEAT;
    wire ehm_len_t wrLen = '{
        hours: regWdata[LEN_HH_LSB +: 5],
        minutes: regWdata[LEN_MM_LSB +: 6],
        seconds: regWdata[LEN_SS_LSB +: 6]
    };
    // out-of-range lengths are refused whole, keeping the old value
    wire logic lenOk = wrLen.hours <= HOURS_MAX && wrLen.minutes <= MINUTES_MAX
        && wrLen.seconds <= SECONDS_MAX;
    wire logic lenUsed = tmode_ff == TM_TIMED || tmode_ff == TM_REPEAT;
    wire logic dispWr = regWr && hitDisp && dispOk;
    wire logic modeWr = regWr && hitTestMode && modeOk;
    wire logic lenWr = regWr && hitTestLen && lenOk;
    wire ehm_len_t nxt_lenApplied = lenUsed ? len_ff : '0;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            disp_ff <= DISP_TOTAL;
            tmode_ff <= TM_UNTIMED;
        end else begin
            if (dispWr) begin
                disp_ff <= wrDisp;
            end
            if (modeWr) begin
                tmode_ff <= wrMode;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            len_ff <= '0;
        end else if (lenWr) begin
            len_ff <= wrLen;
        end
    end

    // the applied copy lags a mode or length change by one cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            lenApplied_ff <= '0;
            lenActive_ff <= 1'b0;
        end else begin
            lenApplied_ff <= nxt_lenApplied;
            lenActive_ff <= lenUsed;
        end
    end

    // ========================================
    // totalize and window measurement
    wire logic winEnd = winCyc_ff == cyc_end(WINDOW_CYCLES);
    // an error on the closing cycle still belongs to the closing window
    wire logic [DATA_W-1:0] winAccInc = bitErrEvt ? sat_inc(winAcc_ff) : winAcc_ff;

    always_ff @(posedge mclk) begin
        if (!resetn || errRestart) begin
            totErr_ff <= '0;
        end else if (bitErrEvt) begin
            totErr_ff <= sat_inc(totErr_ff);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn || errRestart) begin
            winCyc_ff <= '0;
            winAcc_ff <= '0;
            winErr_ff <= '0;
        end else begin
            winCyc_ff <= winEnd ? '0 : winCyc_ff + 32'h1;
            winAcc_ff <= winEnd ? '0 : winAccInc;
            if (winEnd) begin
                winErr_ff <= winAccInc;
            end
        end
    end

    // one status read freezes the window, total and clock counts so they agree with each other
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            snapWin_ff <= '0;
            snapTot_ff <= '0;
            snapFreq_ff <= '0;
        end else if (statusRd) begin
            snapWin_ff <= winErr_ff;
            snapTot_ff <= totErr_ff;
            snapFreq_ff <= rxClkFreq;
        end
    end

    // ========================================
    // short window
    wire logic shortTick = shortPre_ff == cyc_end(TICK_CYCLES);
    wire logic shortFull = shortTicks_ff == TICKS_PER_SEC;
    // counting stops at the one second mark, not when software reads
    wire logic shortCount = bitErrEvt && !shortFull && !shortExpired_ff;
    wire logic [5:0] nxt_shortTicks = (shortTick && !shortFull) ? shortTicks_ff + 6'h1
        : shortTicks_ff;

    // the prescaler restarts with the command so ticks line up with it
    always_ff @(posedge mclk) begin
        if (!resetn || shortRestart) begin
            shortPre_ff <= '0;
            shortTicks_ff <= '0;
            shortExpired_ff <= 1'b0;
        end else begin
            shortPre_ff <= shortTick ? '0 : shortPre_ff + 32'h1;
            shortTicks_ff <= nxt_shortTicks;
            shortExpired_ff <= shortExpired_ff || (shortTick && shortFull);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn || shortRestart) begin
            shortErr_ff <= '0;
        end else if (shortCount) begin
            shortErr_ff <= sat_inc(shortErr_ff);
        end
    end

    wire logic [7:0] shortTickRep = shortExpired_ff ? SHORT_EXPIRED : {2'h0, shortTicks_ff};
    wire logic [DATA_W-1:0] shortWord = {shortErr_ff[23:0], shortTickRep};

    // ========================================
    // test interval results
    wire logic testStart = testRun && !testRun_ff;
    wire logic testStop = !testRun && testRun_ff;
    wire logic [DATA_W-1:0] nxt_testAcc = testStart ? '0
        : (testRun && bitErrEvt) ? sat_inc(testAcc_ff) : testAcc_ff;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            testRun_ff <= 1'b0;
            testAcc_ff <= '0;
        end else begin
            testRun_ff <= testRun;
            testAcc_ff <= nxt_testAcc;
        end
    end

    // a stop in the discard cycle wins, so fresh results are never lost
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            prevRes_ff <= '0;
            prevValid_ff <= 1'b0;
        end else if (testStop) begin
            prevRes_ff <= testAcc_ff;
            prevValid_ff <= 1'b1;
        end else if (testDiscard) begin
            prevValid_ff <= 1'b0;
        end
    end

    // ========================================
    // read path
    wire logic [DATA_W-1:0] statusWord = {27'h0, lock_ff, hist_ff.powerLoss, hist_ff.phaseErr,
        hist_ff.bitErr, hist_ff.syncLoss};
    wire logic [DATA_W-1:0] lenWord = {11'h0, len_ff.hours, 2'h0, len_ff.minutes, 2'h0,
        len_ff.seconds};
    wire logic [DATA_W-1:0] resWord = prevValid_ff ? {1'b1, prevRes_ff[30:0]} : '0;
    wire logic [DATA_W-1:0] dispWord = {30'h0, disp_ff};
    wire logic [DATA_W-1:0] modeWord = {30'h0, tmode_ff};
    wire logic [DATA_W-1:0] rdSel =
        hitDisp ? dispWord :
        hitStatus ? statusWord :
        hitWinErr ? snapWin_ff :
        hitTotErr ? snapTot_ff :
        hitClkFreq ? snapFreq_ff :
        hitShort ? shortWord :
        hitTestMode ? modeWord :
        hitTestLen ? lenWord :
        hitTestRes ? resWord :
        '0;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= regRd ? rdSel : '0;
        end
    end

    // ========================================
    // outputs
    assign regRdata = rdata_ff;
    assign histLed = hist_ff;
    assign lockLed = lock_ff;
    assign dispMode = disp_ff;
    assign testMode = tmode_ff;
    assign testLenApplied = lenApplied_ff;
    assign testLenActive = lenActive_ff;
    assign prevResultValid = prevValid_ff;

endmodule

`default_nettype wire

// ---- test/ehm_top_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module ehm_top_properties
    import ehm_pkg::*;
#(
    parameter int TICK_CYCLES = ehm_pkg::TICK_CYC,
    parameter int WINDOW_CYCLES = ehm_pkg::WIN_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [ehm_pkg::ADDR_W-1:0] regAddr,
    input wire logic [ehm_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [ehm_pkg::DATA_W-1:0] regRdata,
    // detector events
    input wire logic syncLossEvt,
    input wire logic bitErrEvt,
    input wire logic phaseErrEvt,
    input wire logic powerLossEvt,
    input wire logic patternLock,
    input wire logic [ehm_pkg::DATA_W-1:0] rxClkFreq,
    input wire logic testRun,
    // indicators and settings
    input wire ehm_pkg::ehm_hist_t histLed,
    input wire logic lockLed,
    input wire ehm_pkg::ehm_disp_t dispMode,
    input wire ehm_pkg::ehm_tmode_t testMode,
    input wire ehm_pkg::ehm_len_t testLenApplied,
    input wire logic testLenActive,
    input wire logic prevResultValid
);
    import ehm_pkg::*;
    // ========================================
    // decode
    wire logic [3:0] evt = {powerLossEvt, phaseErrEvt, bitErrEvt, syncLossEvt};
    wire logic histClr = regWr && regAddr == OFS_CMD && regWdata[CMD_HIST_CLEAR];
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // ========================================
    // properties
    a_rdata_idle_zero: assert property (!$past(regRd) |-> regRdata == '0)
        else $error("read data not zero outside answer cycle");
    a_lock_follows: assert property ($past(resetn) |-> lockLed == $past(patternLock))
        else $error("lock indicator does not follow sync");
    a_hist_set: assert property ($past(resetn) |-> (histLed & $past(evt)) == $past(evt))
        else $error("indicator not set by event");
    a_hist_hold: assert property ($past(resetn) && !$past(histClr)
        |-> ($past(histLed) & ~histLed) == 4'h0)
        else $error("indicator dropped without clear");
    a_hist_clear: assert property (histClr && evt == 4'h0 |=> histLed == 4'h0)
        else $error("clear left an indicator on");
    a_status_bits: assert property (regRd && regAddr == OFS_STATUS
        |=> regRdata[3:0] == $past(histLed))
        else $error("status bits differ from indicators");
    a_disp_refuse: assert property (regWr && regAddr == OFS_DISP && regWdata[1:0] == 2'h3
        |=> $stable(dispMode))
        else $error("display code 3 accepted");
    a_len_active: assert property ($past(resetn)
        |-> testLenActive == ($past(testMode) inside {TM_TIMED, TM_REPEAT}))
        else $error("length active flag wrong");
    a_len_ignored: assert property (!testLenActive |-> testLenApplied == '0)
        else $error("length applied while untimed");
    a_discard_clears: assert property (regWr && regAddr == OFS_CMD
        && regWdata[CMD_TEST_DISCARD] && (testRun || !$past(testRun))
        |=> !prevResultValid)
        else $error("discard left previous results valid");
    a_valid_rise: assert property ($rose(prevResultValid)
        |-> $past(testRun, 2) && !$past(testRun))
        else $error("previous results valid without a stop");
endmodule
bind ehm_top ehm_top_properties #(
    .TICK_CYCLES(TICK_CYCLES),
    .WINDOW_CYCLES(WINDOW_CYCLES)
) i_ehm_top_properties (.mclk, .resetn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .syncLossEvt, .bitErrEvt, .phaseErrEvt, .powerLossEvt, .patternLock, .rxClkFreq,
    .testRun, .histLed, .lockLed, .dispMode, .testMode, .testLenApplied, .testLenActive,
    .prevResultValid);
`default_nettype wire

// ---- test/ehm_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ehm_ctrl_model (
    // clock
    input wire logic mclk,
    // register port
    output logic [ehm_pkg::ADDR_W-1:0] regAddr,
    output logic [ehm_pkg::DATA_W-1:0] regWdata,
    output logic regWr,
    output logic regRd,
    input wire logic [ehm_pkg::DATA_W-1:0] regRdata
);
    import ehm_pkg::*;
    initial begin
        regAddr = '0;
        regWdata = '0;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    // ========================================
    // bus cycles, one strobe cycle each
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
        // released data must not keep looking valid
        regWdata <= ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        @(posedge mclk);
        d = regRdata;
    endtask
endmodule
`default_nettype wire

// ---- test/error_history_measurement_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module error_history_measurement_bench;
    import ehm_pkg::*;
    logic mclk = 1'b0;
    logic resetn, regWr, regRd, patternLock, testRun, lockLed, testLenActive, prevResultValid;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata, rxClkFreq, d, f, e;
    logic [3:0] evt;
    ehm_hist_t histLed;
    ehm_disp_t dispMode;
    ehm_tmode_t testMode;
    ehm_len_t testLenApplied;
    int seed = 70073;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int k;
    ehm_ctrl_model i_ehm_ctrl_model (.mclk, .regAddr, .regWdata, .regWr, .regRd, .regRdata);
    ehm_top #(.TICK_CYCLES(10), .WINDOW_CYCLES(20)) i_ehm_top (.mclk, .resetn, .regAddr,
        .regWdata, .regWr, .regRd, .regRdata, .syncLossEvt(evt[0]), .bitErrEvt(evt[1]),
        .phaseErrEvt(evt[2]), .powerLossEvt(evt[3]), .patternLock, .rxClkFreq, .testRun,
        .histLed, .lockLed, .dispMode, .testMode, .testLenApplied, .testLenActive,
        .prevResultValid);
    always #2 mclk = ~mclk;
    // ========================================
    // checking and closing
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] v;
        i_ehm_ctrl_model.rd(a, v);
        chk(n, x, v);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            bad_count++;
            wrap_up();
        end
    end
    function automatic logic [31:0] lenw(input int h, input int m, input int s);
        return 32'((h << 16) | (m << 8) | s);
    endfunction
    // ========================================
    // main sequence
    initial begin
        resetn = 1'b0;
        evt = 4'h0;
        patternLock = 1'b0;
        rxClkFreq = '0;
        testRun = 1'b0;
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        #1 chk("reset", 32'h0, 32'({histLed, lockLed, dispMode, testMode, prevResultValid,
            testLenActive, testLenApplied}));
        chk("rdata", 32'h0, regRdata);
        for (int m = 0; m < 4; m++) begin
            i_ehm_ctrl_model.wr(OFS_DISP, 32'(m));
            rchk("disp", OFS_DISP, (m == 3) ? 32'h2 : 32'(m));
            chk("dispPin", (m == 3) ? 32'h2 : 32'(m), 32'(dispMode));
        end
        rchk("unmapped", 8'hFC, 32'h0);
        $display("test display done");
        f = $random(seed);
        rxClkFreq <= f;
        patternLock <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            evt <= 4'h1 << i;
            @(posedge mclk);
            evt <= 4'h0;
            rchk("hist", OFS_STATUS, 32'h10 | ((32'h2 << i) - 32'h1));
            chk("histPin", (32'h2 << i) - 32'h1, 32'(histLed));
        end
        rchk("freq", OFS_CLK_FREQ, f);
        chk("lockPin", 32'h1, 32'(lockLed));
        i_ehm_ctrl_model.wr(OFS_CMD, 32'h2);
        patternLock <= 1'b0;
        repeat (2) @(posedge mclk);
        rchk("clear", OFS_STATUS, 32'h0);
        chk("histPin", 32'h0, 32'(histLed));
        chk("lockPin", 32'h0, 32'(lockLed));
        $display("test history done");
        i_ehm_ctrl_model.wr(OFS_CMD, 32'h1);
        testRun <= 1'b1;
        e = 32'($random(seed) & 15) + 32'h1;
        repeat (2) @(posedge mclk);
        evt[1] <= 1'b1;
        repeat (e) @(posedge mclk);
        evt[1] <= 1'b0;
        repeat (2) @(posedge mclk);
        testRun <= 1'b0;
        // status lands in the second scaled window, over a whole window after restart
        repeat (17 - e) @(posedge mclk);
        rchk("status", OFS_STATUS, 32'h2);
        rchk("total", OFS_TOT_ERR, e);
        rchk("window", OFS_WIN_ERR, e);
        rchk("result", OFS_TEST_RES, 32'h80000000 | e);
        i_ehm_ctrl_model.wr(OFS_CMD, 32'h1);
        // read before the next window closes, so only the restart can zero it
        rchk("status", OFS_STATUS, 32'h2);
        rchk("winClear", OFS_WIN_ERR, 32'h0);
        repeat (40) @(posedge mclk);
        rchk("status", OFS_STATUS, 32'h2);
        rchk("total", OFS_TOT_ERR, 32'h0);
        rchk("kept", OFS_TEST_RES, 32'h80000000 | e);
        i_ehm_ctrl_model.wr(OFS_CMD, 32'h8);
        rchk("discard", OFS_TEST_RES, 32'h0);
        chk("valid", 32'h0, 32'(prevResultValid));
        $display("test results done");
        k = ($random(seed) & 7) + 1;
        i_ehm_ctrl_model.wr(OFS_CMD, 32'h4);
        evt[1] <= 1'b1;
        repeat (k) @(posedge mclk);
        evt[1] <= 1'b0;
        // reads land mid-tick so phase slips of one cycle still pass
        repeat (23 - k) @(posedge mclk);
        rchk("short", OFS_SHORT, 32'((k << 8) | 2));
        repeat (477) @(posedge mclk);
        rchk("short", OFS_SHORT, 32'((k << 8) | 50));
        evt[1] <= 1'b1;
        repeat (4) @(posedge mclk);
        evt[1] <= 1'b0;
        repeat (3) @(posedge mclk);
        rchk("expired", OFS_SHORT, 32'((k << 8) | 8'hFF));
        i_ehm_ctrl_model.wr(OFS_CMD, 32'h4);
        rchk("restart", OFS_SHORT, 32'h0);
        $display("test short window done");
        for (int j = 0; j < 4; j++) begin
            d = (j == 0) ? lenw(24, 59, 59) : lenw($unsigned($random(seed)) % 25,
                $unsigned($random(seed)) % 60, $unsigned($random(seed)) % 60);
            i_ehm_ctrl_model.wr(OFS_TEST_LEN, d);
            rchk("len", OFS_TEST_LEN, d);
        end
        for (int j = 0; j < 3; j++) begin
            i_ehm_ctrl_model.wr(OFS_TEST_LEN, lenw(j == 0 ? 25 : 0, j == 1 ? 60 : 0, j == 2 ? 60 : 0));
            rchk("refused", OFS_TEST_LEN, d);
        end
        for (int m = 0; m < 4; m++) begin
            i_ehm_ctrl_model.wr(OFS_TEST_MODE, 32'(m));
            repeat (2) @(posedge mclk);
            chk("applied", (m == 0) ? 32'h0 : 32'({d[20:16], d[13:8], d[5:0]}),
                32'(testLenApplied));
            chk("active", (m == 0) ? 32'h0 : 32'h1, 32'(testLenActive));
            chk("modePin", (m == 3) ? 32'h2 : 32'(m), 32'(testMode));
        end
        rchk("mode", OFS_TEST_MODE, 32'h2);
        $display("test length done");
        wrap_up();
    end
endmodule
`default_nettype wire
